/* core/sal_pin_unit.sv */
// serial audio pin unit: clock/flag pins, shared data pins, port pins, AXI4-Lite registers
//
// Operation
// - async mode: rx clock pin clocks receivers
// - sync mode: rx clock pin becomes flag zero
// - flag direction follows rx clock direction bit
// - output flag driven, updated per frame/slot
// - input flag captured per frame/slot
// - tx clock pin clocks tx (and rx sync)
// - port pins individually input, output, disconnected
// - reset leaves every pin disconnected
// - data pin zero transmits shift register five
// - data pin zero receives into register zero
// - data pin one transmits shift register four
// - data pin one receives into register one
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module sal_pin_unit
  import sal_pkg::*;
#(
  parameter int WORD_BITS = SAL_WORD_BITS,
  parameter int SLOTS     = SAL_SLOTS,
  parameter int HALF_DIV  = SAL_HALF_DIV
) (
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  input  wire logic                    linkClk,
  input  wire logic [7:0]              awaddr,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  input  wire logic [7:0]              araddr,
  input  wire logic                    arvalid,
  output logic                         arready,
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready,
  input  wire logic [SAL_NUM_PINS-1:0] pinIn,
  output logic      [SAL_NUM_PINS-1:0] pinOut,
  output logic      [SAL_NUM_PINS-1:0] pinOe
);

  localparam int BIT_W  = $clog2(WORD_BITS);
  localparam int SLOT_W = (SLOTS > 1) ? $clog2(SLOTS) : 1;
  localparam int DIV_W  = $clog2(HALF_DIV + 1);
  localparam int CFG_W  = $bits(sal_cfg_type);

  // ----------------------------------------------------------------
  // register state (core domain)
  // ----------------------------------------------------------------
  logic [7:0]       ctrl_q, ctrl_d;
  logic [7:0]       role_q, role_d;
  logic [3:0]       gpOut_q, gpOut_d;
  logic [1:0]       rxFull_q, rxFull_d;
  logic [1:0][31:0] rxData_q, rxData_d;
  logic             awHeld_q, awHeld_d, wHeld_q, wHeld_d;
  logic [7:0]       awAddr_q, awAddr_d;
  logic [31:0]      wData_q, wData_d;
  logic [3:0]       wStrb_q, wStrb_d;
  logic             bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]       bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]      rdata_q, rdata_d;
  logic [DIV_W-1:0] divCnt_q, divCnt_d;
  logic             bitClk_q, bitClk_d;

  sal_cfg_type      cfg, linkCfg;
  logic [3:0]       corePinIn, linkPinIn, gpInView;
  logic             inFlagCore;
  logic [1:0]       txWrite, txBusy, rxNew;
  logic [1:0][31:0] rxNewData;
  logic [31:0]      wMerged;
  logic             doWrite;

  // ----------------------------------------------------------------
  // configuration carrier
  // ----------------------------------------------------------------
  assign cfg = '{role:     role_q,
                 syncMode: ctrl_q[SAL_CTRL_SYNC],
                 rxClkDir: ctrl_q[SAL_CTRL_RXCLKDIR],
                 txClkDir: ctrl_q[SAL_CTRL_TXCLKDIR],
                 outFlag:  ctrl_q[SAL_CTRL_OUTFLAG],
                 netMode:  ctrl_q[SAL_CTRL_NETMODE],
                 dataTx:   {ctrl_q[SAL_CTRL_DATA1TX], ctrl_q[SAL_CTRL_DATA0TX]}};

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign awready = !awHeld_q && !bvalid_q;
  assign wready  = !wHeld_q && !bvalid_q;
  assign arready = !rvalid_q;
  assign doWrite = awHeld_q && wHeld_q;

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wMerged[b*8 +: 8] = wStrb_q[b] ? wData_q[b*8 +: 8] : 8'h00;
    end
  end

  always_comb begin
    awHeld_d = awHeld_q;
    awAddr_d = awAddr_q;
    wHeld_d  = wHeld_q;
    wData_d  = wData_q;
    wStrb_d  = wStrb_q;
    bvalid_d = bvalid_q;
    bresp_d  = bresp_q;
    ctrl_d   = ctrl_q;
    role_d   = role_q;
    gpOut_d  = gpOut_q;
    txWrite  = 2'b00;
    if (awvalid && awready) begin
      awHeld_d = 1'b1;
      awAddr_d = awaddr;
    end
    if (wvalid && wready) begin
      wHeld_d = 1'b1;
      wData_d = wdata;
      wStrb_d = wstrb;
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if (doWrite) begin
      awHeld_d = 1'b0;
      wHeld_d  = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = SAL_RESP_OKAY;
      case ({awAddr_q[7:2], 2'b00})
        SAL_OFS_CTRL: begin
          if (wStrb_q[0]) ctrl_d = wData_q[7:0];
        end
        SAL_OFS_ROLE: begin
          if (wStrb_q[0]) role_d = wData_q[7:0];
        end
        SAL_OFS_GPOUT: begin
          if (wStrb_q[0]) gpOut_d = wData_q[3:0];
        end
        SAL_OFS_TXD0, SAL_OFS_TXD1: begin
          // a word offered while the previous one is still crossing is refused
          // address bit 3 separates lane 0 (0x14) from lane 1 (0x18)
          if (txBusy[awAddr_q[3]]) bresp_d = SAL_RESP_SLVERR;
          else txWrite[awAddr_q[3]] = 1'b1;
        end
        SAL_OFS_GPIN, SAL_OFS_STATUS, SAL_OFS_RXD0, SAL_OFS_RXD1: begin
          bresp_d = SAL_RESP_OKAY;
        end
        default: begin
          bresp_d = SAL_RESP_SLVERR;
        end
      endcase
    end
  end

  always_comb begin
    rvalid_d = rvalid_q;
    rresp_d  = rresp_q;
    rdata_d  = rdata_q;
    rxFull_d = rxFull_q;
    rxData_d = rxData_q;
    if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    if (arvalid && arready) begin
      rvalid_d = 1'b1;
      rresp_d  = SAL_RESP_OKAY;
      rdata_d  = 32'h0000_0000;
      case ({araddr[7:2], 2'b00})
        SAL_OFS_CTRL:   rdata_d[7:0] = ctrl_q;
        SAL_OFS_ROLE:   rdata_d[7:0] = role_q;
        SAL_OFS_GPOUT:  rdata_d[3:0] = gpOut_q;
        SAL_OFS_GPIN:   rdata_d[3:0] = gpInView;
        SAL_OFS_STATUS: begin
          rdata_d[SAL_STAT_INFLAG]      = inFlagCore;
          rdata_d[SAL_STAT_RXFULL +: 2] = rxFull_q;
          rdata_d[SAL_STAT_TXBUSY +: 2] = txBusy;
        end
        SAL_OFS_TXD0, SAL_OFS_TXD1: rdata_d = 32'h0000_0000;
        SAL_OFS_RXD0: begin
          rdata_d     = rxData_q[0];
          rxFull_d[0] = 1'b0;
        end
        SAL_OFS_RXD1: begin
          rdata_d     = rxData_q[1];
          rxFull_d[1] = 1'b0;
        end
        default: rresp_d = SAL_RESP_SLVERR;
      endcase
    end
    // an arriving word beats the clear from a read in the same cycle
    for (int l = 0; l < 2; l++) begin
      if (rxNew[l]) begin
        rxFull_d[l] = 1'b1;
        rxData_d[l] = rxNewData[l];
      end
    end
  end

  // ----------------------------------------------------------------
  // bit clock generator for pins that drive a clock out
  // ----------------------------------------------------------------
  always_comb begin
    divCnt_d = divCnt_q + DIV_W'(1);
    bitClk_d = bitClk_q;
    if (divCnt_q == DIV_W'(HALF_DIV - 1)) begin
      divCnt_d = '0;
      bitClk_d = ~bitClk_q;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_q   <= SAL_CTRL_RESET;
      role_q   <= SAL_ROLE_RESET;
      gpOut_q  <= SAL_GPOUT_RESET;
      rxFull_q <= 2'b00;
      rxData_q <= '0;
      awHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wHeld_q  <= 1'b0;
      wData_q  <= 32'h0000_0000;
      wStrb_q  <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= SAL_RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q  <= SAL_RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
      divCnt_q <= '0;
      bitClk_q <= 1'b0;
    end else begin
      ctrl_q   <= ctrl_d;
      role_q   <= role_d;
      gpOut_q  <= gpOut_d;
      rxFull_q <= rxFull_d;
      rxData_q <= rxData_d;
      awHeld_q <= awHeld_d;
      awAddr_q <= awAddr_d;
      wHeld_q  <= wHeld_d;
      wData_q  <= wData_d;
      wStrb_q  <= wStrb_d;
      bvalid_q <= bvalid_d;
      bresp_q  <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q  <= rresp_d;
      rdata_q  <= rdata_d;
      divCnt_q <= divCnt_d;
      bitClk_q <= bitClk_d;
    end
  end

  assign bvalid = bvalid_q;
  assign bresp  = bresp_q;
  assign rvalid = rvalid_q;
  assign rresp  = rresp_q;
  assign rdata  = rdata_q;

  // ----------------------------------------------------------------
  // crossings
  // ----------------------------------------------------------------
  sal_sync2 #(.WIDTH(SAL_NUM_PINS)) uCorePinSync (
    .clk  (core_clk),
    .rst  (rst),
    .din  (pinIn),
    .dout (corePinIn)
  );

  sal_sync2 #(.WIDTH(SAL_NUM_PINS)) uLinkPinSync (
    .clk  (linkClk),
    .rst  (rst),
    .din  (pinIn),
    .dout (linkPinIn)
  );

  // quasi-static settings; software changes them only while the link is idle
  sal_sync2 #(.WIDTH(CFG_W)) uCfgSync (
    .clk  (linkClk),
    .rst  (rst),
    .din  (cfg),
    .dout (linkCfg)
  );

  // ----------------------------------------------------------------
  // link domain: slot timing, shift registers, flag zero
  // ----------------------------------------------------------------
  logic [BIT_W-1:0]  bitCnt_q, bitCnt_d;
  logic [SLOT_W-1:0] slotCnt_q, slotCnt_d;
  logic [1:0][WORD_BITS-1:0] txShift_q, txShift_d, txPend_q, txPend_d, rxShift_q, rxShift_d;
  logic [1:0][WORD_BITS-1:0] txNewData;
  logic [1:0]        txNew, txBit_q, txBit_d, rxPush, laneFunc;
  logic              outFlag_q, outFlag_d, inFlag_q, inFlag_d;
  logic              wordEnd, frameEnd, flagStrobe;

  assign wordEnd    = bitCnt_q == BIT_W'(WORD_BITS - 1);
  assign frameEnd   = wordEnd && (slotCnt_q == SLOT_W'(SLOTS - 1));
  assign flagStrobe = linkCfg.netMode ? wordEnd : frameEnd;

  always_comb begin
    bitCnt_d  = wordEnd ? '0 : bitCnt_q + BIT_W'(1);
    slotCnt_d = frameEnd ? '0 : (wordEnd ? slotCnt_q + SLOT_W'(1) : slotCnt_q);
    outFlag_d = flagStrobe ? linkCfg.outFlag : outFlag_q;
    inFlag_d  = inFlag_q;
    if (flagStrobe && linkCfg.syncMode && !linkCfg.rxClkDir) begin
      inFlag_d = linkPinIn[SAL_PIN_RXCLK];
    end
    for (int l = 0; l < 2; l++) begin
      laneFunc[l]  = linkCfg.role[(SAL_PIN_DATA0 + l)*2 +: 2] == SAL_ROLE_FUNC;
      txPend_d[l]  = txNew[l] ? txNewData[l] : txPend_q[l];
      txShift_d[l] = wordEnd ? txPend_q[l] : {txShift_q[l][WORD_BITS-2:0], 1'b0};
      txBit_d[l]   = txShift_q[l][WORD_BITS-1];
      rxShift_d[l] = {rxShift_q[l][WORD_BITS-2:0], linkPinIn[SAL_PIN_DATA0 + l]};
      rxPush[l]    = wordEnd && laneFunc[l] && !linkCfg.dataTx[l];
    end
  end

  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      bitCnt_q  <= '0;
      slotCnt_q <= '0;
      txShift_q <= '0;
      txPend_q  <= '0;
      rxShift_q <= '0;
      txBit_q   <= 2'b00;
      outFlag_q <= 1'b0;
      inFlag_q  <= 1'b0;
    end else begin
      bitCnt_q  <= bitCnt_d;
      slotCnt_q <= slotCnt_d;
      txShift_q <= txShift_d;
      txPend_q  <= txPend_d;
      rxShift_q <= rxShift_d;
      txBit_q   <= txBit_d;
      outFlag_q <= outFlag_d;
      inFlag_q  <= inFlag_d;
    end
  end

  sal_sync2 #(.WIDTH(1)) uInFlagSync (
    .clk  (core_clk),
    .rst  (rst),
    .din  (inFlag_q),
    .dout (inFlagCore)
  );

  // lane 0 carries shift registers five/zero, lane 1 four/one
  for (genvar l = 0; l < 2; l++) begin : gLane
    sal_word_cdc #(.WIDTH(WORD_BITS)) uTxCdc (
      .srcClk   (core_clk),
      .srcRst   (rst),
      .srcValid (txWrite[l]),
      .srcData  (wMerged),
      .srcBusy  (txBusy[l]),
      .dstClk   (linkClk),
      .dstRst   (rst),
      .dstValid (txNew[l]),
      .dstData  (txNewData[l])
    );
    // a word finished while the previous is still crossing is lost
    sal_word_cdc #(.WIDTH(WORD_BITS)) uRxCdc (
      .srcClk   (linkClk),
      .srcRst   (rst),
      .srcValid (rxPush[l]),
      .srcData  (rxShift_d[l]),
      .srcBusy  (),
      .dstClk   (core_clk),
      .dstRst   (rst),
      .dstValid (rxNew[l]),
      .dstData  (rxNewData[l])
    );
  end

  // ----------------------------------------------------------------
  // pin multiplexing
  // ----------------------------------------------------------------
  always_comb begin
    for (int p = 0; p < SAL_NUM_PINS; p++) begin
      gpInView[p] = (cfg.role[p*2 +: 2] == SAL_ROLE_GPIN) ? corePinIn[p] : 1'b0;
      pinOut[p]   = 1'b0;
      pinOe[p]    = 1'b0;
      case (sal_role_type'(cfg.role[p*2 +: 2]))
        SAL_ROLE_GPOUT: begin
          pinOut[p] = gpOut_q[p];
          pinOe[p]  = 1'b1;
        end
        SAL_ROLE_FUNC: begin
          if (p == SAL_PIN_RXCLK) begin
            pinOe[p]  = cfg.rxClkDir;
            pinOut[p] = cfg.syncMode ? outFlag_q : bitClk_q;
          end else if (p == SAL_PIN_TXCLK) begin
            pinOe[p]  = cfg.txClkDir;
            pinOut[p] = bitClk_q;
          end else begin
            pinOe[p]  = cfg.dataTx[p - SAL_PIN_DATA0];
            pinOut[p] = cfg.dataTx[p - SAL_PIN_DATA0] & txBit_q[p - SAL_PIN_DATA0];
          end
        end
        default: begin
          pinOut[p] = 1'b0;
          pinOe[p]  = 1'b0;
        end
      endcase
    end
  end

endmodule

/* core/sal_pkg.sv */
// shared constants, register map and carrier types of the serial audio pin block
package sal_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SAL_OFS_CTRL   = 8'h00;
  localparam logic [7:0] SAL_OFS_ROLE   = 8'h04;
  localparam logic [7:0] SAL_OFS_GPOUT  = 8'h08;
  localparam logic [7:0] SAL_OFS_GPIN   = 8'h0C;
  localparam logic [7:0] SAL_OFS_STATUS = 8'h10;
  localparam logic [7:0] SAL_OFS_TXD0   = 8'h14;
  localparam logic [7:0] SAL_OFS_TXD1   = 8'h18;
  localparam logic [7:0] SAL_OFS_RXD0   = 8'h1C;
  localparam logic [7:0] SAL_OFS_RXD1   = 8'h20;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int SAL_CTRL_SYNC     = 0;
  localparam int SAL_CTRL_RXCLKDIR = 1;
  localparam int SAL_CTRL_OUTFLAG  = 2;
  localparam int SAL_CTRL_NETMODE  = 3;
  localparam int SAL_CTRL_TXCLKDIR = 4;
  localparam int SAL_CTRL_DATA0TX  = 5;
  localparam int SAL_CTRL_DATA1TX  = 6;
  localparam int SAL_STAT_INFLAG   = 0;
  localparam int SAL_STAT_RXFULL   = 1;
  localparam int SAL_STAT_TXBUSY   = 3;

  localparam logic [7:0]  SAL_CTRL_RESET  = 8'h00;
  localparam logic [7:0]  SAL_ROLE_RESET  = 8'h00;
  localparam logic [3:0]  SAL_GPOUT_RESET = 4'h0;

  // pin slots: receiver clock, transmitter clock, shared data 0 and 1
  localparam int SAL_PIN_RXCLK = 0;
  localparam int SAL_PIN_TXCLK = 1;
  localparam int SAL_PIN_DATA0 = 2;
  localparam int SAL_NUM_PINS  = 4;

  // ----------------------------------------------------------------
  // counts
  // ----------------------------------------------------------------
  localparam int SAL_WORD_BITS = 32;
  localparam int SAL_SLOTS     = 2;
  localparam int SAL_HALF_DIV  = 6;

  localparam logic [1:0] SAL_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SAL_RESP_SLVERR = 2'h2;

  // two role bits per pin; reset code is the disconnected port state
  typedef enum logic [1:0] {
    SAL_ROLE_DISC  = 2'h0,
    SAL_ROLE_GPIN  = 2'h1,
    SAL_ROLE_GPOUT = 2'h2,
    SAL_ROLE_FUNC  = 2'h3
  } sal_role_type;

  typedef struct packed {
    logic [7:0] role;
    logic       syncMode;
    logic       rxClkDir;
    logic       txClkDir;
    logic       outFlag;
    logic       netMode;
    logic [1:0] dataTx;
  } sal_cfg_type;

endpackage

/* core/sal_sync2.sv */
// two-flop level synchroniser
`timescale 1ns/1ps
module sal_sync2
  import sal_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else begin
      stage1_q <= din;
      stage2_q <= stage1_q;
    end
  end

  assign dout = stage2_q;

endmodule

/* core/sal_word_cdc.sv */
// toggle handshake that carries one word between clock domains
`timescale 1ns/1ps
module sal_word_cdc
  import sal_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input  wire logic             srcClk,
  input  wire logic             srcRst,
  input  wire logic             srcValid,
  input  wire logic [WIDTH-1:0] srcData,
  output logic                  srcBusy,
  input  wire logic             dstClk,
  input  wire logic             dstRst,
  output logic                  dstValid,
  output logic      [WIDTH-1:0] dstData
);

  logic             reqT_q;
  logic             reqT_d;
  logic [WIDTH-1:0] hold_q;
  logic [WIDTH-1:0] hold_d;
  logic             ackSync;
  logic             reqSync;
  logic             reqSeen_q;
  logic             dstValid_q;
  logic             dstValid_d;
  logic [WIDTH-1:0] dstData_q;
  logic [WIDTH-1:0] dstData_d;

  // hold stays frozen while busy, so the far side may copy it safely
  assign srcBusy = reqT_q ^ ackSync;

  always_comb begin
    reqT_d = reqT_q;
    hold_d = hold_q;
    if (srcValid && !srcBusy) begin
      reqT_d = ~reqT_q;
      hold_d = srcData;
    end
  end

  always_ff @(posedge srcClk or posedge srcRst) begin
    if (srcRst) begin
      reqT_q <= 1'b0;
      hold_q <= '0;
    end else begin
      reqT_q <= reqT_d;
      hold_q <= hold_d;
    end
  end

  sal_sync2 #(.WIDTH(1)) uReqSync (
    .clk  (dstClk),
    .rst  (dstRst),
    .din  (reqT_q),
    .dout (reqSync)
  );

  sal_sync2 #(.WIDTH(1)) uAckSync (
    .clk  (srcClk),
    .rst  (srcRst),
    .din  (reqSeen_q),
    .dout (ackSync)
  );

  always_comb begin
    dstValid_d = reqSync ^ reqSeen_q;
    dstData_d  = dstValid_d ? hold_q : dstData_q;
  end

  always_ff @(posedge dstClk or posedge dstRst) begin
    if (dstRst) begin
      reqSeen_q  <= 1'b0;
      dstValid_q <= 1'b0;
      dstData_q  <= '0;
    end else begin
      reqSeen_q  <= reqSync;
      dstValid_q <= dstValid_d;
      dstData_q  <= dstData_d;
    end
  end

  assign dstValid = dstValid_q;
  assign dstData  = dstData_q;

endmodule

/* tb/sal_codec_model.sv */
// far-side codec model: flag source, bit clock and two serial data sources
`timescale 1ns/1ps
module sal_codec_model
  import sal_pkg::*;
(
  input  wire logic        linkClk,
  input  wire logic [3:0]  pinOut,
  input  wire logic [3:0]  pinOe,
  input  wire logic        flagLvl,
  input  wire logic [31:0] word0,
  input  wire logic [31:0] word1,
  output logic      [3:0]  pinIn
);
  // ---------------------------------------------
  // serial source
  // ---------------------------------------------
  logic [4:0] bitIdx = 5'h00;
  // changes on the falling edge, away from the sampling edge
  always @(negedge linkClk) bitIdx <= bitIdx + 5'h01;
  // a driven pin shows the design's level, else the codec's own
  assign pinIn[0] = pinOe[0] ? pinOut[0] : flagLvl;
  assign pinIn[1] = pinOe[1] ? pinOut[1] : linkClk;
  assign pinIn[2] = pinOe[2] ? pinOut[2] : word0[5'h1F - bitIdx];
  assign pinIn[3] = pinOe[3] ? pinOut[3] : word1[5'h1F - bitIdx];
endmodule

/* tb/sal_pin_unit_chk.sv */
// port-level checker of the serial audio pin unit
`timescale 1ns/1ps
module sal_pin_unit_chk (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       awvalid,
  input wire logic       awready,
  input wire logic       wvalid,
  input wire logic       wready,
  input wire logic       bvalid,
  input wire logic       bready,
  input wire logic [1:0] bresp,
  input wire logic       arvalid,
  input wire logic       arready,
  input wire logic       rvalid,
  input wire logic       rready,
  input wire logic [31:0] rdata,
  input wire logic [3:0] pinOe
);
  // ---------------------------------------------
  // helper and assertions
  // ---------------------------------------------
  logic wrSeen_q;
  logic wrSeen_d;
  always_comb wrSeen_d = wrSeen_q | (wvalid & wready);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) wrSeen_q <= 1'b0;
    else wrSeen_q <= wrSeen_d;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  pins_idle_a: assert property (!wrSeen_q |-> pinOe == 4'h0)
    else $error("pin driven before any write");
  wr_resp_a: assert property (awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
    else $error("write response not two cycles after take");
  b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  b_block_a: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while response pending");
  b_done_a: assert property (bvalid && bready |=> !bvalid)
    else $error("write response not retired");
  rd_resp_a: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data changed while waiting");
  r_block_a: assert property (rvalid |-> !arready)
    else $error("read accepted while data pending");
endmodule
bind sal_pin_unit sal_pin_unit_chk i_sal_pin_unit_chk (.core_clk, .rst, .awvalid, .awready, .wvalid, .wready,
  .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata, .pinOe);

/* tb/tb.sv */
// self-checking bench of the serial audio pin unit
`timescale 1ns/1ps
module tb;
  import sal_pkg::*;
  logic        core_clk = 1'b0;
  logic        linkClk  = 1'b0;
  logic        rst      = 1'b1;
  logic [7:0]  awaddr   = 8'h00;
  logic        awvalid  = 1'b0;
  logic [31:0] wdata    = 32'h0;
  logic [3:0]  wstrb    = 4'h0;
  logic        wvalid   = 1'b0;
  logic        bready   = 1'b0;
  logic [7:0]  araddr   = 8'h00;
  logic        arvalid  = 1'b0;
  logic        rready   = 1'b0;
  logic        flagLvl  = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rs;
  logic [31:0] rdata, rd_v, cap2, cap3;
  logic [3:0]  pinIn, pinOut, pinOe;
  int          err_count, n_compared, cyc;
  localparam logic [31:0] RX0 = 32'h0000_00F1;
  localparam logic [31:0] RX1 = 32'h0000_0F03;
  localparam logic [31:0] TX0 = 32'hA5C3_0017;
  localparam logic [31:0] TX1 = 32'h1234_5678;

  sal_pin_unit i_sal_pin_unit (.core_clk, .rst, .linkClk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .pinIn,
    .pinOut, .pinOe);
  sal_codec_model i_sal_codec_model (.linkClk, .pinOut, .pinOe, .flagLvl, .word0(RX0), .word1(RX1), .pinIn);

  initial forever #2 core_clk = ~core_clk;
  initial begin
    #7;
    forever #24 linkClk = ~linkClk;
  end
  always @(posedge linkClk) begin
    cap2 <= {cap2[30:0], pinOut[2]};
    cap3 <= {cap3[30:0], pinOut[3]};
  end
  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  function automatic logic [31:0] is_rot(input logic [31:0] w, input logic [31:0] v);
    logic [63:0] ww;
    ww = {w, w};
    for (int i = 0; i < 32; i++) if (ww[i+:32] === v) return 32'h1;
    return 32'h0;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    @(posedge core_clk);
    awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(negedge core_clk);
      ah = awvalid & awready; wh = wvalid & wready; bh = bvalid; rs = bresp;
      @(posedge core_clk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end while (!bh);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    logic ah, rh;
    @(posedge core_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(negedge core_clk);
      ah = arvalid & arready; rh = rvalid; rd_v = rdata; rs = rresp;
      @(posedge core_clk);
      if (ah) arvalid <= 1'b0;
    end while (!rh);
    rready <= 1'b0;
  endtask
  task automatic lk(input int n);
    repeat (n) @(posedge linkClk);
    @(negedge core_clk);
  endtask
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic t_reset;
    chk(32'h0, {28'h0, pinOe});
    rd(SAL_OFS_CTRL); chk(32'h0, rd_v);
    chk({30'h0, SAL_RESP_OKAY}, {30'h0, rs});
    rd(SAL_OFS_ROLE); chk(32'h0, rd_v);
    rd(SAL_OFS_GPOUT); chk(32'h0, rd_v);
    $display("reset test done");
  endtask
  task automatic t_gpio;
    wr(SAL_OFS_GPOUT, 32'h5); chk({30'h0, SAL_RESP_OKAY}, {30'h0, rs});
    wr(SAL_OFS_ROLE, 32'hAA); @(negedge core_clk);
    chk(32'hF, {28'h0, pinOe});
    chk(32'h5, {28'h0, pinOut});
    flagLvl <= 1'b1;
    wr(SAL_OFS_ROLE, 32'h09); lk(2);
    chk(32'h2, {28'h0, pinOe});
    rd(SAL_OFS_GPIN); chk(32'h1, rd_v);
    $display("port test done");
  endtask
  task automatic t_clk;
    int n0, n1;
    logic p0, p1;
    wr(SAL_OFS_CTRL, 32'h12); wr(SAL_OFS_ROLE, 32'h0F);
    n0 = 0; n1 = 0; @(negedge core_clk); p0 = pinOut[0]; p1 = pinOut[1];
    repeat (48) begin
      @(negedge core_clk);
      if (pinOut[0] !== p0) n0++;
      if (pinOut[1] !== p1) n1++;
      p0 = pinOut[0]; p1 = pinOut[1];
    end
    chk(32'h3, {30'h0, pinOe[1:0]});
    chk(32'h8, n0);
    chk(32'h8, n1);
    $display("clock test done");
  endtask
  task automatic t_flag;
    wr(SAL_OFS_ROLE, 32'h03); wr(SAL_OFS_CTRL, 32'h07); lk(80);
    chk(32'h3, {30'h0, pinOe[0], pinOut[0]});
    wr(SAL_OFS_CTRL, 32'h03); lk(80);
    chk(32'h2, {30'h0, pinOe[0], pinOut[0]});
    // network mode updates the flag every word, well inside one frame
    wr(SAL_OFS_CTRL, 32'h0F); lk(40);
    chk(32'h3, {30'h0, pinOe[0], pinOut[0]});
    wr(SAL_OFS_CTRL, 32'h01); flagLvl <= 1'b1; lk(80);
    chk(32'h0, {31'h0, pinOe[0]});
    rd(SAL_OFS_STATUS); chk(32'h1, {31'h0, rd_v[0]});
    flagLvl <= 1'b0; lk(80);
    rd(SAL_OFS_STATUS); chk(32'h0, {31'h0, rd_v[0]});
    $display("flag test done");
  endtask
  task automatic t_data;
    wr(SAL_OFS_CTRL, 32'h60); wr(SAL_OFS_ROLE, 32'hF0);
    wr(SAL_OFS_TXD0, TX0); wr(SAL_OFS_TXD1, TX1); lk(100);
    chk(32'h3, {30'h0, pinOe[3:2]});
    chk(32'h1, is_rot(TX0, cap2));
    chk(32'h1, is_rot(TX1, cap3));
    wr(SAL_OFS_CTRL, 32'h00); lk(100);
    chk(32'h0, {30'h0, pinOe[3:2]});
    rd(SAL_OFS_STATUS); chk(32'h3, {30'h0, rd_v[2:1]});
    rd(SAL_OFS_RXD0); chk(32'h1, is_rot(RX0, rd_v));
    rd(SAL_OFS_RXD1); chk(32'h1, is_rot(RX1, rd_v));
    $display("data test done");
  endtask
  task automatic t_bad;
    wr(8'h40, 32'hFFFF_FFFF); chk({30'h0, SAL_RESP_SLVERR}, {30'h0, rs});
    rd(8'h40); chk({30'h0, SAL_RESP_SLVERR}, {30'h0, rs});
    chk(32'h0, rd_v);
    $display("unmapped test done");
  endtask
  // ---------------------------------------------
  // run control
  // ---------------------------------------------
  task automatic finish_test;
    $display("compared=%0d mismatches=%0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin
    err_count = 0; n_compared = 0; cyc = 0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    t_reset(); t_gpio(); t_clk(); t_flag(); t_data(); t_bad();
    finish_test();
  end
endmodule
